// ===== core/ppo_map.vh
// register map, field positions and reset values of the pin override block
`ifndef PPO_MAP_VH
`define PPO_MAP_VH

`define PPO_ADDR_W          4
`define PPO_A_DIR           4'h0
`define PPO_A_DATA          4'h1
`define PPO_A_PIN           4'h2
`define PPO_A_CTRL          4'h3
`define PPO_A_IRQ_STAT      4'h4
`define PPO_A_IRQ_MASK      4'h5
`define PPO_A_SPI_CTRL      4'h6
`define PPO_A_EXT_CTRL      4'h7

`define PPO_CTRL_PULLUP_OFF 4
`define PPO_SPI_EN          0
`define PPO_SPI_MASTER      1
`define PPO_EXT_EN0         0
`define PPO_EXT_EN1         1

`define PPO_IRQ_WAKE0       0
`define PPO_IRQ_WAKE1       1

`define PPO_PIN_MOSI        4
`define PPO_PIN_SCK         5
`define PPO_PIN_MISO        6
`define PPO_PIN_CAP         7
`define PPO_PIN_EXT0        2
`define PPO_PIN_PWM0        1

`define PPO_RST_BYTE        8'h00

`endif

// ===== core/ppo_pin_cell.v
// one pin: pull-up, driver, value and input-enable override muxing
`timescale 1ns/1ps
module ppo_pin_cell (
    input  wire i_dir,
    input  wire i_data,
    input  wire i_global_pullup_disable,
    input  wire i_sleep,
    input  wire i_pullup_override_enable,
    input  wire i_pullup_override_value,
    input  wire i_direction_override_enable,
    input  wire i_direction_override_value,
    input  wire i_value_override_enable,
    input  wire i_value_override_value,
    input  wire i_input_enable_override_enable,
    input  wire i_input_enable_override_value,
    input  wire i_pad_in,
    output wire o_pullup,
    output wire o_drive_en,
    output wire o_drive_val,
    output wire o_input_en,
    output wire o_alternate_digital_input
);
    // pure combinational so overrides hit the pad in the same cycle  see RULE17
    assign o_pullup    = i_pullup_override_enable ? i_pullup_override_value    // see RULE5
                       : (~i_dir & i_data & ~i_global_pullup_disable); // see RULE4 see RULE12
    assign o_drive_en  = i_direction_override_enable ? i_direction_override_value
                       : i_dir;                                        // see RULE6 see RULE16
    assign o_drive_val = o_drive_en & (i_value_override_enable ? i_value_override_value
                       : i_data);                                      // see RULE7 see RULE16
    assign o_input_en  = i_input_enable_override_enable ? i_input_enable_override_value
                       : ~i_sleep;                                     // see RULE9 see RULE1
    // clamp to ground ahead of the buffer; consumer synchronises it  see RULE10
    assign o_alternate_digital_input = i_pad_in & o_input_en;
endmodule // ppo_pin_cell

// ===== core/ppo_port.v
// eight-pin port with peripheral overrides, sleep clamp and register port
`timescale 1ns/1ps
`include "ppo_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Function
// (RULE1) deep sleep clamps each pin input to ground unless overridden
// (RULE2) an enabled external interrupt pin is exempt from the sleep clamp
// (RULE3) disabled interrupt pin high during clamp flags its interrupt on wake
// (RULE4) without override, pull-up on only for dir 0, data 1, disable 0
// (RULE5) with pull-up override enabled, pull-up follows the override value
// (RULE6) driver enable follows direction override value or the direction bit
// (RULE7) driven value is value override or the data bit
// (RULE8) toggle override enable inverts the pin data bit
// (RULE9) input enable override forces input enable regardless of sleep
// (RULE10) alternate input taken after buffer, before synchroniser
// (RULE11) override signals come from the owning peripheral, not the port; spi and interrupt ones come from spi_ctrl and ext_en here
// (RULE12) global pull-up disable bit 4 switches off every pull-up
// (RULE13) pin 7 carries pwm2 output 2 and timer1 capture input
// (RULE14) pin 4 mosi, pin 6 miso, pin 5 sck and external interrupt 1
// (RULE15) pin 2 interrupt 0 and pwm2 output 1; pin 1 pwm2 output 0
// (RULE16) direction one makes output, zero input; data sets driven level
// (RULE17) override muxing is combinational per pin
module ppo_port #(
    parameter N = 8
) (
    input  wire                  i_mclk,
    input  wire                  i_rst,
    input  wire [`PPO_ADDR_W-1:0] i_addr,
    input  wire [7:0]            i_wdata,
    input  wire                  i_wr,
    input  wire                  i_rd,
    output reg  [7:0]            o_rdata,
    input  wire                  i_sleep_deep,
    input  wire [N-1:0]          i_pad_in,
    output wire [N-1:0]          o_pad_out,
    output wire [N-1:0]          o_pad_oe,
    output wire [N-1:0]          o_pad_pullup,
    input  wire                  i_pwm2_en0,
    input  wire                  i_pwm2_output_0,
    input  wire                  i_pwm2_en1,
    input  wire                  i_pwm2_output_1,
    input  wire                  i_pwm2_en2,
    input  wire                  i_pwm2_output_2,
    input  wire                  i_spi_mosi_out,
    input  wire                  i_spi_miso_out,
    input  wire                  i_spi_sck_out,
    input  wire [N-1:0]          i_toggle_override_enable,
    output wire                  o_timer1_capture_input,
    output wire                  o_spi_mosi_in,
    output wire                  o_spi_miso_in,
    output wire                  o_spi_sck_in,
    output wire                  o_ext_interrupt_0_input,
    output wire                  o_ext_interrupt_1_input,
    output wire                  o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    reg  [N-1:0] dir;
    reg  [N-1:0] data;
    reg  [7:0]   processor_control;
    reg  [1:0]   spi_ctrl;
    reg  [1:0]   ext_en;
    reg  [1:0]   irq_stat;
    reg  [1:0]   irq_mask;
    reg  [1:0]   wake_pend;
    reg  [N-1:0] sy1;
    reg  [N-1:0] sy2;
    reg  [N-1:0] sy3;
    reg  [N-1:0] pin_sync;
    reg          sleep_q;

    wire         global_pullup_disable = processor_control[`PPO_CTRL_PULLUP_OFF];
    wire         spi_on  = spi_ctrl[`PPO_SPI_EN];
    wire         spi_mst = spi_on & spi_ctrl[`PPO_SPI_MASTER];
    wire         spi_slv = spi_on & ~spi_ctrl[`PPO_SPI_MASTER];
    wire [N-1:0] adi;
    wire [N-1:0] input_en;

    // register map, one byte per address:
    //   0 direction, a one makes the pin an output
    //   1 output data, also the pull-up request of an input
    //   2 synchronised pin levels; writing ones toggles data
    //   3 processor control, bit 4 turns every pull-up off
    //   4 wake status, bit 0 pin 2, bit 1 pin 5, write one clears
    //   5 wake mask, same layout as the status
    //   6 spi control, bit 0 enable, bit 1 master
    //   7 external interrupt enables, bit 0 pin 2, bit 1 pin 5
    //   other addresses read zero and ignore writes

    // pin map of the alternate functions:
    //   pin 1 pwm2 output 0
    //   pin 2 pwm2 output 1 and external interrupt 0
    //   pin 4 spi data out of a master, into a slave
    //   pin 5 spi clock and external interrupt 1
    //   pin 6 spi data into a master, out of a slave
    //   pin 7 pwm2 output 2 and timer1 capture input
    //   pins 0 and 3 are plain port bits here

    // override priority per pin, highest first:
    //   a peripheral enable replaces the register bit outright
    //   the register bit decides when no peripheral claims the pin
    //   the sleep clamp yields to an input enable override

    // pad outputs are combinational, so a peripheral that flips
    // its enable moves the pad in the same cycle; the price is
    // that glitches on the enables reach the pad

    // raw inputs handed to peripherals are not synchronised;
    // a consumer must add its own flops unless it uses one as
    // a clock

    // the pin register path waits for flops two and three to
    // agree, so a read lags a pad change by about four cycles

    // limitation: pin 5 is shared, and an enabled interrupt keeps
    // its input alive even while the spi master drives the clock

    // wake flags mimic the edge the clamp makes: a pin left high
    // with its interrupt off falls in sleep and rises on wake

    // toggle requests from software and peripherals are ored, then xored into data;
    // two requests on one bit in one cycle still give one flip

    // reset leaves every pin an input with no pull-up or drive,
    // so the pads float until software configures them

    // read data answers one cycle after the strobe and is zero
    // in every other cycle, so stale data never lingers

    // sleep is taken as a level; its registered copy gives the
    // falling edge that sets the wake flags

    // an spi pin forced to input keeps the software pull-up:
    //   on only for data 1 and global disable 0

    // override bundles: pwm bits from the pwm2 enables, spi and interrupt bits from spi_ctrl and ext_en  see RULE11
    reg  [N-1:0] pullup_override_enable;
    reg  [N-1:0] pullup_override_value;
    reg  [N-1:0] direction_override_enable;
    reg  [N-1:0] direction_override_value;
    reg  [N-1:0] value_override_enable;
    reg  [N-1:0] value_override_value;
    reg  [N-1:0] input_enable_override_enable;
    reg  [N-1:0] input_enable_override_value;

    always @* begin
        pullup_override_enable       = {N{1'b0}};
        pullup_override_value        = {N{1'b0}};
        direction_override_enable    = {N{1'b0}};
        direction_override_value     = {N{1'b0}};
        value_override_enable        = {N{1'b0}};
        value_override_value         = {N{1'b0}};
        input_enable_override_enable = {N{1'b0}};
        input_enable_override_value  = {N{1'b0}};

        // pwm stage two outputs  see RULE13 see RULE15
        direction_override_enable[`PPO_PIN_CAP]  = i_pwm2_en2;
        direction_override_value[`PPO_PIN_CAP]   = 1'b1;
        value_override_enable[`PPO_PIN_CAP]      = i_pwm2_en2;
        value_override_value[`PPO_PIN_CAP]       = i_pwm2_output_2;

        direction_override_enable[`PPO_PIN_EXT0] = i_pwm2_en1;
        direction_override_value[`PPO_PIN_EXT0]  = 1'b1;
        value_override_enable[`PPO_PIN_EXT0]     = i_pwm2_en1;
        value_override_value[`PPO_PIN_EXT0]      = i_pwm2_output_1;

        direction_override_enable[`PPO_PIN_PWM0] = i_pwm2_en0;
        direction_override_value[`PPO_PIN_PWM0]  = 1'b1;
        value_override_enable[`PPO_PIN_PWM0]     = i_pwm2_en0;
        value_override_value[`PPO_PIN_PWM0]      = i_pwm2_output_0;

        // spi: inputs forced on the receiving side, pull-up still software's  see RULE14
        pullup_override_enable[`PPO_PIN_MISO]    = spi_mst;
        pullup_override_value[`PPO_PIN_MISO]     = data[`PPO_PIN_MISO] & ~global_pullup_disable;
        direction_override_enable[`PPO_PIN_MISO] = spi_mst;
        value_override_enable[`PPO_PIN_MISO]     = spi_slv;
        value_override_value[`PPO_PIN_MISO]      = i_spi_miso_out;

        pullup_override_enable[`PPO_PIN_SCK]     = spi_slv;
        pullup_override_value[`PPO_PIN_SCK]      = data[`PPO_PIN_SCK] & ~global_pullup_disable;
        direction_override_enable[`PPO_PIN_SCK]  = spi_slv;
        value_override_enable[`PPO_PIN_SCK]      = spi_mst;
        value_override_value[`PPO_PIN_SCK]       = i_spi_sck_out;

        pullup_override_enable[`PPO_PIN_MOSI]    = spi_slv;
        pullup_override_value[`PPO_PIN_MOSI]     = data[`PPO_PIN_MOSI] & ~global_pullup_disable;
        direction_override_enable[`PPO_PIN_MOSI] = spi_slv;
        value_override_enable[`PPO_PIN_MOSI]     = spi_mst;
        value_override_value[`PPO_PIN_MOSI]      = i_spi_mosi_out;

        // enabled external interrupts keep their input alive in sleep  see RULE2
        input_enable_override_enable[`PPO_PIN_EXT0] = ext_en[`PPO_EXT_EN0];
        input_enable_override_value[`PPO_PIN_EXT0]  = ext_en[`PPO_EXT_EN0];
        input_enable_override_enable[`PPO_PIN_SCK]  = ext_en[`PPO_EXT_EN1];
        input_enable_override_value[`PPO_PIN_SCK]   = ext_en[`PPO_EXT_EN1];
    end

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : pin
            ppo_pin_cell u_cell (
                .i_dir                          (dir[g]),
                .i_data                         (data[g]),
                .i_global_pullup_disable        (global_pullup_disable),
                .i_sleep                        (i_sleep_deep),
                .i_pullup_override_enable       (pullup_override_enable[g]),
                .i_pullup_override_value        (pullup_override_value[g]),
                .i_direction_override_enable    (direction_override_enable[g]),
                .i_direction_override_value     (direction_override_value[g]),
                .i_value_override_enable        (value_override_enable[g]),
                .i_value_override_value         (value_override_value[g]),
                .i_input_enable_override_enable (input_enable_override_enable[g]),
                .i_input_enable_override_value  (input_enable_override_value[g]),
                .i_pad_in                       (i_pad_in[g]),
                .o_pullup                       (o_pad_pullup[g]),
                .o_drive_en                     (o_pad_oe[g]),
                .o_drive_val                    (o_pad_out[g]),
                .o_input_en                     (input_en[g]),
                .o_alternate_digital_input      (adi[g])
            );
        end
    endgenerate

    // raw pre-synchroniser inputs to the peripherals  see RULE10 see RULE13 see RULE14
    assign o_timer1_capture_input  = adi[`PPO_PIN_CAP];
    assign o_spi_mosi_in           = adi[`PPO_PIN_MOSI];
    assign o_spi_miso_in           = adi[`PPO_PIN_MISO];
    assign o_spi_sck_in            = adi[`PPO_PIN_SCK];
    assign o_ext_interrupt_0_input = adi[`PPO_PIN_EXT0];                // see RULE15
    assign o_ext_interrupt_1_input = adi[`PPO_PIN_SCK];                 // see RULE14
    assign o_irq = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // port read path: three flops, value moves once stages two and three agree
    always @(posedge i_mclk) begin
        if (i_rst) begin
            sy1      <= {N{1'b0}};
            sy2      <= {N{1'b0}};
            sy3      <= {N{1'b0}};
            pin_sync <= {N{1'b0}};
        end else begin
            sy1 <= adi;
            sy2 <= sy1;
            sy3 <= sy2;
            pin_sync <= (sy2 == sy3) ? sy3 : pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake flag: a disabled interrupt pin seen high is clamped to low in sleep,
    // so leaving sleep yields the edge the interrupt logic would see  see RULE3
    wire       wake    = sleep_q & ~i_sleep_deep;
    wire [1:0] hi_now  = {pin_sync[`PPO_PIN_SCK], pin_sync[`PPO_PIN_EXT0]};
    wire [1:0] wr_clr  = (i_wr && i_addr == `PPO_A_IRQ_STAT) ? i_wdata[1:0] : 2'h0;
    wire [1:0] irq_set = wake ? wake_pend : 2'h0;

    always @(posedge i_mclk) begin
        if (i_rst) begin
            sleep_q   <= 1'b0;
            wake_pend <= 2'h0;
            irq_stat  <= 2'h0;
        end else begin
            sleep_q <= i_sleep_deep;
            if (!i_sleep_deep)
                wake_pend <= hi_now & ~ext_en;                          // see RULE3
            irq_stat <= (irq_stat & ~wr_clr) | irq_set;                 // set wins over clear
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    wire [N-1:0] pin_wr = (i_wr && i_addr == `PPO_A_PIN) ? i_wdata[N-1:0] : {N{1'b0}};

    always @(posedge i_mclk) begin
        if (i_rst) begin
            dir               <= {N{1'b0}};
            data              <= {N{1'b0}};
            processor_control <= `PPO_RST_BYTE;
            spi_ctrl          <= 2'h0;
            ext_en            <= 2'h0;
            irq_mask          <= 2'h0;
        end else begin
            if (i_wr && i_addr == `PPO_A_DIR)
                dir <= i_wdata[N-1:0];                                  // see RULE16
            // software pin-write toggles and peripheral toggle both invert  see RULE8
            if (i_wr && i_addr == `PPO_A_DATA)
                data <= i_wdata[N-1:0] ^ i_toggle_override_enable;
            else
                data <= data ^ (pin_wr | i_toggle_override_enable);
            if (i_wr && i_addr == `PPO_A_CTRL)
                processor_control <= i_wdata;                           // see RULE12
            if (i_wr && i_addr == `PPO_A_SPI_CTRL)
                spi_ctrl <= i_wdata[1:0];
            if (i_wr && i_addr == `PPO_A_EXT_CTRL)
                ext_en <= i_wdata[1:0];
            if (i_wr && i_addr == `PPO_A_IRQ_MASK)
                irq_mask <= i_wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `PPO_A_DIR:      o_rdata <= dir;
                `PPO_A_DATA:     o_rdata <= data;
                `PPO_A_PIN:      o_rdata <= pin_sync;
                `PPO_A_CTRL:     o_rdata <= processor_control;
                `PPO_A_IRQ_STAT: o_rdata <= {6'h00, irq_stat};
                `PPO_A_IRQ_MASK: o_rdata <= {6'h00, irq_mask};
                `PPO_A_SPI_CTRL: o_rdata <= {6'h00, spi_ctrl};
                `PPO_A_EXT_CTRL: o_rdata <= {6'h00, ext_en};
                default:         o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule // ppo_port

// ===== bench/ppo_port_monitor.sv
// port-level assertions of the pin override port
`timescale 1ns/1ps
`include "ppo_map.vh"
module ppo_port_monitor #(
    parameter N = 8
) (
    input wire                   i_mclk,
    input wire                   i_rst,
    input wire [`PPO_ADDR_W-1:0] i_addr,
    input wire [7:0]             i_wdata,
    input wire                   i_wr,
    input wire                   i_rd,
    input wire [7:0]             o_rdata,
    input wire                   i_sleep_deep,
    input wire [N-1:0]           o_pad_out,
    input wire [N-1:0]           o_pad_oe,
    input wire [N-1:0]           o_pad_pullup,
    input wire                   i_pwm2_en0,
    input wire                   i_pwm2_output_0,
    input wire                   i_pwm2_en2,
    input wire                   i_pwm2_output_2,
    input wire [N-1:0]           i_toggle_override_enable,
    input wire                   o_timer1_capture_input
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////
    pwm_pin1_a: assert property (i_pwm2_en0 |-> o_pad_oe[1] && o_pad_out[1] == i_pwm2_output_0)
        else $error("pin 1 not carrying pwm output 0");
    pwm_pin7_a: assert property (i_pwm2_en2 |-> o_pad_oe[7] && o_pad_out[7] == i_pwm2_output_2)
        else $error("pin 7 not carrying pwm output 2");
    out_off_a: assert property ((o_pad_out & ~o_pad_oe) == '0)
        else $error("pad value driven while driver off");
    cap_clamp_a: assert property (i_sleep_deep |-> !o_timer1_capture_input)
        else $error("capture input not clamped in deep sleep");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    dir_write_a: assert property (i_wr && i_addr == `PPO_A_DIR |=> o_pad_oe[0] == $past(i_wdata[0]))
        else $error("pin 0 driver not following direction");
    data_write_a: assert property (i_wr && i_addr == `PPO_A_DATA && !i_toggle_override_enable[0]
        |=> o_pad_out[0] == (o_pad_oe[0] & $past(i_wdata[0])))
        else $error("pin 0 value not following data");
    toggle_flip_a: assert property (i_toggle_override_enable[0] && !i_wr && o_pad_oe[0]
        |=> o_pad_out[0] != $past(o_pad_out[0]))
        else $error("toggle did not invert pin 0");
    pud_off_a: assert property (i_wr && i_addr == `PPO_A_CTRL && i_wdata[4] |=> o_pad_pullup == '0)
        else $error("pull-up left on under global disable");
    cover property (i_sleep_deep);
    cover property (i_toggle_override_enable[0] && o_pad_oe[0]);
    cover property (i_pwm2_en2 && i_pwm2_output_2);
endmodule // ppo_port_monitor

// ===== bench/ppo_periph.sv
// stand-in for the pwm stage and spi that own the pin overrides
`timescale 1ns/1ps
module ppo_periph (
    input  wire       i_mclk,
    input  wire [8:0] i_cmd,
    input  wire       i_ext0,
    output reg  [2:0] o_pwm_en = 3'h0,
    output reg  [2:0] o_pwm_val = 3'h0,
    output reg  [2:0] o_spi = 3'h0,
    output reg        o_ext0_sync = 1'b0
);
    reg ext0_meta = 1'b0;
    // overrides come from the owning peripheral, a cycle after the bench asks
    always @(posedge i_mclk) begin
        {o_spi, o_pwm_val, o_pwm_en} <= i_cmd;
    end
    // the raw interrupt input is unsynchronised, so this side adds two flops
    always @(posedge i_mclk) begin
        ext0_meta <= i_ext0;
        o_ext0_sync <= ext0_meta;
    end
endmodule // ppo_periph

// ===== bench/ppo_port_tb.sv
// self-checking bench of the pin override port
`timescale 1ns/1ps
`include "ppo_map.vh"
module ppo_port_tb;
    localparam N = 8;
    logic         i_mclk = 1'b0;
    logic         i_rst = 1'b1;
    logic [3:0]   i_addr = 4'h0;
    logic [7:0]   i_wdata = 8'h00;
    logic         i_wr = 1'b0;
    logic         i_rd = 1'b0;
    logic         i_sleep_deep = 1'b0;
    logic [N-1:0] i_pad_in = 8'h00;
    logic [N-1:0] i_tog = 8'h00;
    logic [8:0]   cmd = 9'h000;
    wire  [7:0]   o_rdata;
    wire  [N-1:0] o_pad_out, o_pad_oe, o_pad_pullup;
    wire  [2:0]   pwm_en, pwm_val, spi;
    wire          ext0_sync, o_cap, o_mosi, o_miso, o_sck, o_ext0, o_ext1, o_irq;
    int           mismatches = 0;
    int           tests_run = 0;
    logic [56:0]  rows [0:6];
    always #12.5 i_mclk = ~i_mclk;
    ppo_periph peer (.i_mclk(i_mclk), .i_cmd(cmd), .i_ext0(o_ext0), .o_pwm_en(pwm_en),
        .o_pwm_val(pwm_val), .o_spi(spi), .o_ext0_sync(ext0_sync));
    ppo_port #(.N(N)) uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep_deep(i_sleep_deep),
        .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
        .o_pad_pullup(o_pad_pullup), .i_pwm2_en0(pwm_en[0]), .i_pwm2_output_0(pwm_val[0]),
        .i_pwm2_en1(pwm_en[1]), .i_pwm2_output_1(pwm_val[1]), .i_pwm2_en2(pwm_en[2]),
        .i_pwm2_output_2(pwm_val[2]), .i_spi_mosi_out(spi[0]), .i_spi_miso_out(spi[1]),
        .i_spi_sck_out(spi[2]), .i_toggle_override_enable(i_tog),
        .o_timer1_capture_input(o_cap), .o_spi_mosi_in(o_mosi), .o_spi_miso_in(o_miso),
        .o_spi_sck_in(o_sck), .o_ext_interrupt_0_input(o_ext0),
        .o_ext_interrupt_1_input(o_ext1), .o_irq(o_irq));
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_mclk) i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_mclk) {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_mclk) i_rd <= 1'b0;
        @(negedge i_mclk) chk("rdata", o_rdata, e);
    endtask
    // a hung run must still reach the verdict
    initial begin
        repeat (5000) @(posedge i_mclk);
        mismatches++;
        stop_test();
    end
    ////////////////////////////////////////
    // row: dir, data, ctrl, {spi, pwm val, pwm en}, expected oe, out, pull-up
    initial begin
        rows[0] = {8'h00, 8'hFF, 8'h00, 9'h000, 8'h00, 8'h00, 8'hFF};
        rows[1] = {8'h00, 8'hFF, 8'h10, 9'h000, 8'h00, 8'h00, 8'h00};
        rows[2] = {8'hFF, 8'hA5, 8'h00, 9'h000, 8'hFF, 8'hA5, 8'h00};
        rows[3] = {8'h0F, 8'h3C, 8'h00, 9'h000, 8'h0F, 8'h0C, 8'h30};
        rows[4] = {8'h00, 8'h00, 8'h00, 9'h03F, 8'h86, 8'h86, 8'h00};
        rows[5] = {8'hFF, 8'hFF, 8'h00, 9'h007, 8'hFF, 8'h79, 8'h00};
        rows[6] = {8'h00, 8'hFF, 8'h00, 9'h00D, 8'h82, 8'h02, 8'hFF};
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(negedge i_mclk);
        chk("oe_rst", o_pad_oe, 8'h00);
        chk("pu_rst", o_pad_pullup, 8'h00);
        for (int k = 0; k < 7; k++) begin
            wr(`PPO_A_DIR, rows[k][56:49]);
            wr(`PPO_A_DATA, rows[k][48:41]);
            wr(`PPO_A_CTRL, rows[k][40:33]);
            @(posedge i_mclk) cmd <= rows[k][32:24];
            repeat (2) @(negedge i_mclk);
            chk("oe", o_pad_oe, rows[k][23:16]);
            chk("out", o_pad_out, rows[k][15:8]);
            chk("pullup", o_pad_pullup, rows[k][7:0]);
            rd(`PPO_A_DIR, rows[k][56:49]);
        end
        wr(`PPO_A_DIR, 8'hFF);
        wr(`PPO_A_SPI_CTRL, 8'h03);
        @(negedge i_mclk);
        chk("miso_oe", {7'h00, o_pad_oe[6]}, 8'h00);
        chk("miso_pu", {7'h00, o_pad_pullup[6]}, 8'h01);
        wr(`PPO_A_SPI_CTRL, 8'h01);
        @(negedge i_mclk);
        chk("slave_oe", {6'h00, o_pad_oe[5:4]}, 8'h00);
        wr(`PPO_A_DATA, 8'h00);
        @(posedge i_mclk) i_tog <= 8'h01;
        @(posedge i_mclk) i_tog <= 8'h00;
        rd(`PPO_A_DATA, 8'h01);
        wr(`PPO_A_PIN, 8'h01);
        rd(`PPO_A_DATA, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        wr(`PPO_A_IRQ_MASK, 8'h00);
        @(posedge i_mclk) i_pad_in <= 8'hFF;
        repeat (5) @(negedge i_mclk);
        chk("ext0_sync", {7'h00, ext0_sync}, 8'h01);
        rd(`PPO_A_PIN, 8'hFF);
        chk("spi_in", {5'h00, o_mosi, o_miso, o_sck}, 8'h07);
        @(posedge i_mclk) i_pad_in <= 8'h7F;
        #1 chk("cap_raw", {7'h00, o_cap}, 8'h00);
        @(posedge i_mclk) {i_pad_in, i_sleep_deep} <= {8'hFF, 1'b1};
        @(negedge i_mclk);
        chk("clamp", {3'h0, o_mosi, o_miso, o_sck, o_cap, o_ext0}, 8'h00);
        wr(`PPO_A_EXT_CTRL, 8'h01);
        @(negedge i_mclk);
        chk("exempt", {6'h00, o_ext0, o_ext1}, 8'h02);
        wr(`PPO_A_EXT_CTRL, 8'h00);
        @(negedge i_mclk);
        chk("reclamp", {7'h00, o_ext0}, 8'h00);
        @(posedge i_mclk) i_sleep_deep <= 1'b0;
        repeat (3) @(negedge i_mclk);
        chk("irq_masked", {7'h00, o_irq}, 8'h00);
        rd(`PPO_A_IRQ_STAT, 8'h03);
        wr(`PPO_A_IRQ_MASK, 8'h01);
        @(negedge i_mclk);
        chk("irq_on", {7'h00, o_irq}, 8'h01);
        wr(`PPO_A_IRQ_STAT, 8'h01);
        @(negedge i_mclk);
        chk("irq_off", {7'h00, o_irq}, 8'h00);
        rd(`PPO_A_IRQ_STAT, 8'h02);
        stop_test();
    end
endmodule // ppo_port_tb
bind ppo_port ppo_port_monitor #(.N(N)) mon (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sleep_deep(i_sleep_deep), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
    .o_pad_pullup(o_pad_pullup), .i_pwm2_en0(i_pwm2_en0), .i_pwm2_output_0(i_pwm2_output_0),
    .i_pwm2_en2(i_pwm2_en2), .i_pwm2_output_2(i_pwm2_output_2),
    .i_toggle_override_enable(i_toggle_override_enable),
    .o_timer1_capture_input(o_timer1_capture_input));
